// file: logic/phy_mgmt_pkg.sv
// shared constants and carriers for the management register bank
package phy_mgmt_pkg;

  // register indices; byte address is index shifted by BYTE_SHIFT
  localparam logic [7:0] IDX_LP_NP     = 8'h08;
  localparam logic [7:0] IDX_MMD_CTRL  = 8'h0D;
  localparam logic [7:0] IDX_MMD_AD    = 8'h0E;
  localparam logic [7:0] IDX_TX_STATUS = 8'h10;
  localparam logic [7:0] IDX_BYPASS    = 8'h12;
  localparam logic [7:0] IDX_RXERR     = 8'h13;
  localparam logic [7:0] IDX_SOFT_CTRL = 8'h1F;
  localparam int         BYTE_SHIFT    = 2;
  localparam int         IDX_W         = 8;

  // field positions of the indirect-access control register
  localparam int MMD_FUNC_HI = 15;
  localparam int MMD_FUNC_LO = 14;
  localparam int MMD_DEV_HI  = 4;

  // status extension bit positions
  localparam int ST_LOCK     = 15;
  localparam int ST_FLAG_HI  = 14;
  localparam int ST_LINK     = 12;
  localparam int ST_RX_ERR   = 11;
  localparam int ST_FLAG_LO  = 8;

  // own control register bits
  localparam int SOFT_RST_BIT  = 15;
  localparam int STICKY_EN_BIT = 9;

  // bypass control layout and defaults
  localparam logic [15:0] BYPASS_RESET  = 16'h0088;
  localparam logic [15:0] BYPASS_RW     = 16'hFEF8;
  localparam logic [15:0] BYPASS_STICKY = 16'h00B8;

  localparam int          RXERR_W   = 8;
  localparam logic [1:0]  HTRANS_NS = 2'h2;
  localparam logic        HRESP_OK  = 1'b0;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    FN_ADDR   = 2'h0,
    FN_DATA   = 2'h1,
    FN_INC_RW = 2'h2,
    FN_INC_WR = 2'h3
  } mmd_func_t;

  // self-clearing error events, one-cycle pulses, ordered as status bits 14..8, except link_gap: bit 12 shows link, link_gap is not read back
  typedef struct packed {
    logic lock_err;
    logic disconnect;
    logic link_gap;
    logic rx_err;
    logic tx_err;
    logic start_stream_delimiter_err;
    logic end_stream_delimiter_err;
  } pcs_events_t;

  // live levels from the 100 Mbit/s receive path
  typedef struct packed {
    logic descr_lock;
    logic link_up;
  } link_state_t;

  // bypass controls, ordered as bypass register bits 15..3
  typedef struct packed {
    logic tx_disable;
    logic skip_4b5b;
    logic skip_scrambler;
    logic skip_descrambler;
    logic skip_pcs_rx;
    logic skip_pcs_tx;
    logic skip_link_fail_inhibit_timer;
    logic rsvd8;
    logic no_automatic_crossover_forced;
    logic rsvd6;
    logic no_pair_swap;
    logic no_polarity_fix;
    logic pdet_honour_adv;
  } bypass_t;

endpackage : phy_mgmt_pkg

// file: logic/mmd_regfile.sv
// small memory holding the indirectly reached registers
`timescale 1ns/100ps
module mmd_regfile #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // registered read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // storage array, no reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data always from a register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : mmd_regfile

// file: logic/sat_counter.sv
// saturating event counter with clear
`timescale 1ns/100ps
module sat_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  // count
  output logic      [W-1:0] count_o
);
  localparam logic [W-1:0] MAX = '1;
  localparam logic [W-1:0] ONE = W'(1);

  // an increment in the clearing cycle is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (clr_i) begin
      count_o <= inc_i ? ONE : '0;
    end else if (inc_i && count_o != MAX) begin
      count_o <= count_o + ONE;
    end
  end
endmodule : sat_counter

// file: logic/phy_mgmt_status_bypass_regs.sv
// management register bank: next page, indirect access, status, bypass, error count
`timescale 1ns/100ps
// Notes on behaviour
// - partner next-page word reads back read-only, zero after reset
// - toggle bit shows complement of our last transmitted toggle, as received
// - message-page bit: 1 message page, 0 unformatted page
// - function field: 00 address, 01 data, 10 inc on rw, 11 inc on write
// - five-bit field selects the target indirect device
// - in address mode the window holds the address, else carries data
// - address advances after data rw in 10, writes only in 11, never in 01
// - descrambler lock and current link show live, zero after reset
// - six error flags stick until read, then clear themselves
// - transmit-disable bit turns off the line transmitter, default 0
// - bypass bits skip 4B/5B coding, scrambler, descrambler independently
// - bypass bits skip PCS receive and PCS transmit
// - bypass bit skips the link-fail-inhibit timer
// - sticky bit, default 1, disables crossover at forced speed
// - sticky bit, default 0, disables pair-swap correction
// - sticky bit, default 0, disables polarity correction
// - sticky bit, default 1: parallel detect honours advertised abilities
// - sticky bits survive soft reset only while sticky-reset enable is set
// - 8-bit receive error count saturates at 255, clears on read
module phy_mgmt_status_bypass_regs #(
  parameter int DEV_BITS = 2,
  parameter int REG_BITS = 5
) (
  // clock and reset
  input  wire logic                       CLOCK_I,
  input  wire logic                       SYS_RST_I,
  // AHB-Lite slave
  input  wire logic                       HSEL_I,
  input  wire logic [31:0]                HADDR_I,
  input  wire logic [1:0]                 HTRANS_I,
  input  wire logic                       HWRITE_I,
  input  wire logic [2:0]                 HSIZE_I,
  input  wire logic [31:0]                HWDATA_I,
  input  wire logic                       HREADY_I,
  output logic      [31:0]                HRDATA_O,
  output logic                            HREADYOUT_O,
  output logic                            HRESP_O,
  // from auto-negotiation and receive path
  input  wire logic                       NP_RX_VALID_I,
  input  wire logic [15:0]                NP_RX_WORD_I,
  input  wire phy_mgmt_pkg::pcs_events_t  PCS_EVENTS_I,
  input  wire phy_mgmt_pkg::link_state_t  LINK_STATE_I,
  input  wire logic                       RX_ERR_FRAME_I,
  // controls to the datapath
  output phy_mgmt_pkg::bypass_t           BYPASS_O,
  output logic                            SOFT_RESET_O
);
  localparam int MEM_AW = DEV_BITS + REG_BITS;
  localparam int MMD_DEV_W = phy_mgmt_pkg::MMD_DEV_HI + 1;

  // refuse shapes the indirect store cannot serve
  if (DEV_BITS < 1 || DEV_BITS > 5 || REG_BITS < 1 || REG_BITS > 16) begin : g_chk
    $error("mmd store shape out of range");
  end

  // bus phase state
  logic                          dp_act;
  logic                          dp_write;
  logic                          dp_hit;
  logic [phy_mgmt_pkg::IDX_W-1:0] dp_idx;
  logic                          rd_wait;
  logic                          acc_valid;
  logic                          wr_fire;
  logic                          rd_fire;
  // register contents
  logic [15:0]                   lp_np;
  phy_mgmt_pkg::mmd_func_t       mmd_func;
  logic [MMD_DEV_W-1:0]          mmd_dev;
  logic [15:0]                   mmd_addr;
  logic [15:0]                   mem_rdata;
  logic [6:0]                    err_flags;
  logic [15:0]                   bypass;
  logic                          sticky_en;
  logic [phy_mgmt_pkg::RXERR_W-1:0] rxerr_count;
  logic [15:0]                   rd_value;

  // true when the current data phase targets the given index
  function automatic logic hit(input logic [phy_mgmt_pkg::IDX_W-1:0] target);
    return dp_hit && (dp_idx == target);
  endfunction : hit

  // true when the function field selects a data access
  function automatic logic is_data(input phy_mgmt_pkg::mmd_func_t f);
    return f != phy_mgmt_pkg::FN_ADDR;
  endfunction : is_data

  // transfer strobes; reads take one wait state
  assign acc_valid   = HSEL_I && HTRANS_I == phy_mgmt_pkg::HTRANS_NS && HREADY_I;
  assign wr_fire     = dp_act && dp_write;
  assign rd_fire     = rd_wait;
  assign HREADYOUT_O = !rd_wait;
  assign HRESP_O     = phy_mgmt_pkg::HRESP_OK;

  // address phase capture
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dp_act   <= 1'b0;
      dp_write <= 1'b0;
      dp_hit   <= 1'b0;
      dp_idx   <= '0;
    end else if (HREADYOUT_O) begin
      dp_act   <= acc_valid;
      dp_write <= HWRITE_I;
      dp_hit   <= HADDR_I[31:phy_mgmt_pkg::BYTE_SHIFT+phy_mgmt_pkg::IDX_W] == '0;
      dp_idx   <= HADDR_I[phy_mgmt_pkg::BYTE_SHIFT +: phy_mgmt_pkg::IDX_W];
    end
  end

  // one wait cycle per read
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= acc_valid && !HWRITE_I && HREADYOUT_O;
    end
  end

  // partner next-page word, stored as received
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lp_np <= '0;
    end else if (NP_RX_VALID_I) begin
      lp_np <= NP_RX_WORD_I;
    end
  end

  // own control: soft reset pulse and sticky-reset enable
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SOFT_RESET_O <= 1'b0;
      sticky_en    <= 1'b1;
    end else begin
      SOFT_RESET_O <= wr_fire && hit(phy_mgmt_pkg::IDX_SOFT_CTRL)
                      && HWDATA_I[phy_mgmt_pkg::SOFT_RST_BIT];
      if (wr_fire && hit(phy_mgmt_pkg::IDX_SOFT_CTRL)) begin
        sticky_en <= HWDATA_I[phy_mgmt_pkg::STICKY_EN_BIT];
      end
    end
  end

  // indirect-access control and address pointer
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mmd_func <= phy_mgmt_pkg::FN_ADDR;
      mmd_dev  <= '0;
      mmd_addr <= '0;
    end else if (SOFT_RESET_O) begin
      mmd_func <= phy_mgmt_pkg::FN_ADDR;
      mmd_dev  <= '0;
      mmd_addr <= '0;
    end else if (wr_fire && hit(phy_mgmt_pkg::IDX_MMD_CTRL)) begin
      mmd_func <= phy_mgmt_pkg::mmd_func_t'(
                  HWDATA_I[phy_mgmt_pkg::MMD_FUNC_HI:phy_mgmt_pkg::MMD_FUNC_LO]);
      mmd_dev  <= HWDATA_I[phy_mgmt_pkg::MMD_DEV_HI:0];
    end else if (wr_fire && hit(phy_mgmt_pkg::IDX_MMD_AD)) begin
      unique case (mmd_func)
        phy_mgmt_pkg::FN_ADDR:   mmd_addr <= HWDATA_I[15:0];
        phy_mgmt_pkg::FN_DATA:   mmd_addr <= mmd_addr;
        phy_mgmt_pkg::FN_INC_RW,
        phy_mgmt_pkg::FN_INC_WR: mmd_addr <= mmd_addr + 16'h0001;
      endcase
    end else if (rd_fire && hit(phy_mgmt_pkg::IDX_MMD_AD)
                 && mmd_func == phy_mgmt_pkg::FN_INC_RW) begin
      mmd_addr <= mmd_addr + 16'h0001;
    end
  end

  // indirect register store, indexed by device and address
  mmd_regfile #(
    .AW (MEM_AW),
    .DW (16)
  ) u_store (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .we_i    (wr_fire && hit(phy_mgmt_pkg::IDX_MMD_AD) && is_data(mmd_func)),
    .waddr_i ({mmd_dev[DEV_BITS-1:0], mmd_addr[REG_BITS-1:0]}),
    .wdata_i (HWDATA_I[15:0]),
    .raddr_i ({mmd_dev[DEV_BITS-1:0], mmd_addr[REG_BITS-1:0]}),
    .rdata_o (mem_rdata)
  );

  // error flags: events set, a read of the status clears, set wins
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      err_flags <= '0;
    end else if (rd_fire && hit(phy_mgmt_pkg::IDX_TX_STATUS)) begin
      err_flags <= PCS_EVENTS_I;
    end else begin
      err_flags <= err_flags | PCS_EVENTS_I;
    end
  end

  // bypass control with sticky handling on soft reset
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      bypass <= phy_mgmt_pkg::BYPASS_RESET;
    end else if (wr_fire && hit(phy_mgmt_pkg::IDX_BYPASS)) begin
      bypass <= HWDATA_I[15:0] & phy_mgmt_pkg::BYPASS_RW;
    end else if (SOFT_RESET_O) begin
      bypass <= sticky_en
        ? ((bypass & phy_mgmt_pkg::BYPASS_STICKY)
           | (phy_mgmt_pkg::BYPASS_RESET & ~phy_mgmt_pkg::BYPASS_STICKY))
        : phy_mgmt_pkg::BYPASS_RESET;
    end
  end

  // bypass bits drive the datapath directly
  assign BYPASS_O = bypass[15:3];

  // receive error frames counted, cleared when read
  sat_counter #(
    .W (phy_mgmt_pkg::RXERR_W)
  ) u_rxerr (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .inc_i   (RX_ERR_FRAME_I),
    .clr_i   (rd_fire && hit(phy_mgmt_pkg::IDX_RXERR)),
    .count_o (rxerr_count)
  );

  // read multiplexer; unmapped reads return zero
  always_comb begin
    rd_value = '0;
    if (dp_hit) begin
      unique case (dp_idx)
        phy_mgmt_pkg::IDX_LP_NP:     rd_value = lp_np;
        phy_mgmt_pkg::IDX_MMD_CTRL:  rd_value = {mmd_func, 9'h000, mmd_dev};
        phy_mgmt_pkg::IDX_MMD_AD:
          rd_value = is_data(mmd_func) ? mem_rdata : mmd_addr;
        phy_mgmt_pkg::IDX_TX_STATUS:
          rd_value = {LINK_STATE_I.descr_lock, err_flags[6:5],
                      LINK_STATE_I.link_up, err_flags[3:0], 8'h00};
        phy_mgmt_pkg::IDX_BYPASS:    rd_value = bypass;
        phy_mgmt_pkg::IDX_RXERR:     rd_value = {8'h00, rxerr_count};
        phy_mgmt_pkg::IDX_SOFT_CTRL:
          rd_value = {6'h00, sticky_en, 9'h000};
        default:                     rd_value = '0;
      endcase
    end
  end

  // read data captured at the end of the wait cycle
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= phy_mgmt_pkg::RD_ZERO;
    end else if (rd_fire) begin
      HRDATA_O <= {16'h0000, rd_value};
    end
  end

  // checks on the bank
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  a_np_capture: assert property (
    NP_RX_VALID_I |=> lp_np == $past(NP_RX_WORD_I))
    else $error("next-page word not captured");
  a_np_toggle: assert property (
    NP_RX_VALID_I ##1 rd_fire && hit(phy_mgmt_pkg::IDX_LP_NP) && !NP_RX_VALID_I
    |=> HRDATA_O[11] == $past(NP_RX_WORD_I[11], 2))
    else $error("toggle bit read back wrong");
  a_np_msg_page: assert property (
    NP_RX_VALID_I |=> lp_np[13] == $past(NP_RX_WORD_I[13]))
    else $error("message page bit wrong");
  a_func_store: assert property (
    wr_fire && hit(phy_mgmt_pkg::IDX_MMD_CTRL) && !SOFT_RESET_O
    |=> mmd_func == $past(HWDATA_I[15:14]) && mmd_dev == $past(HWDATA_I[4:0]))
    else $error("function or device field not stored");
  a_addr_mode: assert property (
    wr_fire && hit(phy_mgmt_pkg::IDX_MMD_AD) && mmd_func == phy_mgmt_pkg::FN_ADDR
    && !SOFT_RESET_O |=> mmd_addr == $past(HWDATA_I[15:0]))
    else $error("address mode write not stored");
  a_addr_inc: assert property (
    !SOFT_RESET_O && ((wr_fire && hit(phy_mgmt_pkg::IDX_MMD_AD) && mmd_func[1])
    || (rd_fire && hit(phy_mgmt_pkg::IDX_MMD_AD) && mmd_func == phy_mgmt_pkg::FN_INC_RW))
    |=> mmd_addr == $past(mmd_addr) + 16'h0001)
    else $error("address did not advance");
  a_addr_hold: assert property (
    !SOFT_RESET_O && (rd_fire || wr_fire) && hit(phy_mgmt_pkg::IDX_MMD_AD)
    && (mmd_func == phy_mgmt_pkg::FN_DATA
        || (rd_fire && mmd_func == phy_mgmt_pkg::FN_INC_WR))
    |=> $stable(mmd_addr))
    else $error("address moved when it should hold");
  a_flag_set: assert property (
    PCS_EVENTS_I != '0 |=> (err_flags & $past(PCS_EVENTS_I)) == $past(PCS_EVENTS_I))
    else $error("error event lost");
  a_flag_clear: assert property (
    rd_fire && hit(phy_mgmt_pkg::IDX_TX_STATUS) && PCS_EVENTS_I == '0
    |=> err_flags == '0)
    else $error("flags not cleared by read");
  a_tx_disable: assert property (
    wr_fire && hit(phy_mgmt_pkg::IDX_BYPASS)
    |=> BYPASS_O.tx_disable == $past(HWDATA_I[15]))
    else $error("transmit disable not applied");
  a_sticky_reset: assert property (
    SOFT_RESET_O && !sticky_en && !(wr_fire && hit(phy_mgmt_pkg::IDX_BYPASS))
    |=> bypass == phy_mgmt_pkg::BYPASS_RESET)
    else $error("soft reset kept sticky bits");
  a_count_sat: assert property (
    rxerr_count == 8'hFF && !(rd_fire && hit(phy_mgmt_pkg::IDX_RXERR))
    |=> rxerr_count == 8'hFF)
    else $error("error count wrapped");
  a_count_inc: assert property (
    RX_ERR_FRAME_I && rxerr_count != 8'hFF && !(rd_fire && hit(phy_mgmt_pkg::IDX_RXERR))
    |=> rxerr_count == $past(rxerr_count) + 8'h01)
    else $error("error frame not counted");

  c_read_wait: cover property (acc_valid && !HWRITE_I ##1 rd_wait ##1 HREADYOUT_O);
  c_count_sat: cover property (rxerr_count == 8'hFF && RX_ERR_FRAME_I);
  c_mmd_inc:   cover property (wr_fire && hit(phy_mgmt_pkg::IDX_MMD_AD) && mmd_func[1]);
  c_flag_read: cover property (rd_fire && hit(phy_mgmt_pkg::IDX_TX_STATUS) && err_flags != '0);

endmodule : phy_mgmt_status_bypass_regs

// file: sim/mgmt_master.sv
// station management master model issuing single AHB-Lite word transfers
`timescale 1ns/100ps
module mgmt_master (
  // clock and bus answer
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // bus request
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  logic        hang;
  logic [31:0] rdat;

  // idle bus at time zero
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0000_0000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0000_0000;
    hang     = 1'b0;
    rdat     = 32'h0000_0000;
  end

  // wait for hready high at a rising edge; answer taken at that same edge
  task automatic wait_ready();
    int   n;
    logic rdy;
    n   = 0;
    rdy = 1'b0;
    while (!rdy && n < 20) begin
      @(posedge clk_i);
      rdy  = (hready_i === 1'b1);
      rdat = hrdata_i;
      n++;
    end
    if (!rdy) begin
      hang = 1'b1;
    end
  endtask : wait_ready

  // one transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel_o   <= 1'b1;
    htrans_o <= phy_mgmt_pkg::HTRANS_NS;
    haddr_o  <= addr;
    hwrite_o <= wr;
    wait_ready();
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd; // control words carry function and device fields
    wait_ready();
    hwdata_o <= ~wd; // stale data is not left standing
    rd = rdat;
  endtask : xfer
endmodule : mgmt_master

// file: sim/testbench.sv
// self-checking bench for the management register bank
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic wr; logic [7:0] idx; logic [15:0] data;} row_t;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  localparam logic [7:0] LP = phy_mgmt_pkg::IDX_LP_NP;
  localparam logic [7:0] CT = phy_mgmt_pkg::IDX_MMD_CTRL;
  localparam logic [7:0] AD = phy_mgmt_pkg::IDX_MMD_AD;
  localparam logic [7:0] ST = phy_mgmt_pkg::IDX_TX_STATUS;
  localparam logic [7:0] BP = phy_mgmt_pkg::IDX_BYPASS;
  localparam logic [7:0] EC = phy_mgmt_pkg::IDX_RXERR;
  localparam logic [7:0] SC = phy_mgmt_pkg::IDX_SOFT_CTRL;

  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      hsel, hwrite, hreadyout, hresp;
  logic [31:0]               haddr, hwdata, hrdata;
  logic [1:0]                htrans;
  logic [2:0]                hsize;
  logic                      np_valid = 1'b0;
  logic [15:0]               np_word = 16'h0000;
  phy_mgmt_pkg::pcs_events_t events = '0;
  phy_mgmt_pkg::link_state_t link = '0;
  logic                      rx_err_frame = 1'b0;
  phy_mgmt_pkg::bypass_t     bypass;
  logic                      soft_rst;
  int                        n_mismatch = 0;
  int                        checked = 0;
  int                        n_soft = 0;

  // ordinary register traffic: write rows drive, read rows expect
  row_t rows [0:39] = '{
    '{W, BP, 16'hFFFF}, '{R, BP, 16'hFEF8}, '{W, BP, 16'h0000}, '{R, BP, 16'h0000},
    '{W, LP, 16'hFFFF}, '{R, LP, 16'h0000}, '{W, CT, 16'hFFFF}, '{R, CT, 16'hC01F},
    '{W, CT, 16'h0003}, '{W, AD, 16'h0004}, '{R, AD, 16'h0004}, '{W, CT, 16'hC003},
    '{W, AD, 16'h1111}, '{W, AD, 16'h2222}, '{W, CT, 16'h0003}, '{R, AD, 16'h0006},
    '{W, AD, 16'h0004}, '{W, CT, 16'hC003}, '{R, AD, 16'h1111}, '{R, AD, 16'h1111},
    '{W, CT, 16'h8003}, '{R, AD, 16'h1111}, '{R, AD, 16'h2222}, '{W, AD, 16'h3333},
    '{W, CT, 16'h0003}, '{R, AD, 16'h0007}, '{W, CT, 16'h4003}, '{W, AD, 16'h5555},
    '{R, AD, 16'h5555}, '{W, CT, 16'h0003}, '{R, AD, 16'h0007}, '{W, CT, 16'h0001},
    '{W, AD, 16'h0004}, '{W, CT, 16'h4001}, '{W, AD, 16'h9999}, '{W, CT, 16'h0003},
    '{W, AD, 16'h0004}, '{W, CT, 16'h4003}, '{R, AD, 16'h1111}, '{W, CT, 16'h0000}};

  // clock and soft reset pulse counter
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (soft_rst === 1'b1) begin
      n_soft <= n_soft + 1;
    end
  end

  mgmt_master m (.clk_i(clk), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  phy_mgmt_status_bypass_regs uut (.CLOCK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .NP_RX_VALID_I(np_valid), .NP_RX_WORD_I(np_word), .PCS_EVENTS_I(events),
    .LINK_STATE_I(link), .RX_ERR_FRAME_I(rx_err_frame), .BYPASS_O(bypass),
    .SOFT_RESET_O(soft_rst));

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // bus access; a hung handshake ends the run
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [15:0] wd,
                     output logic [15:0] rd);
    logic [31:0] r32;
    m.xfer(wr, addr, {16'h0000, wd}, r32);
    if (m.hang) begin
      n_mismatch++;
      end_sim();
    end
    rd = r32[15:0];
  endtask : bus

  task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] r;
    bus(W, 32'(idx) << phy_mgmt_pkg::BYTE_SHIFT, d, r);
  endtask : wreg

  task automatic rchk(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] r;
    bus(R, 32'(idx) << phy_mgmt_pkg::BYTE_SHIFT, 16'h0000, r);
    check($sformatf("register %h", idx), r, exp);
  endtask : rchk

  // link-side stimulus, entered just after a rising edge
  task automatic pulse_ev(input phy_mgmt_pkg::pcs_events_t ev);
    events <= ev;
    @(posedge clk);
    events <= '0;
    @(posedge clk);
  endtask : pulse_ev

  task automatic pulse_np(input logic [15:0] w);
    np_valid <= 1'b1;
    np_word  <= w;
    @(posedge clk);
    np_valid <= 1'b0;
    np_word  <= ~w;
    @(posedge clk);
  endtask : pulse_np

  task automatic pulse_rx(input int n);
    rx_err_frame <= 1'b1;
    repeat (n) @(posedge clk);
    rx_err_frame <= 1'b0;
    @(posedge clk);
  endtask : pulse_rx

  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    check("bypass in reset", 16'(bypass), 16'h0011);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // main sequence
  initial begin
    do_reset();
    rchk(LP, 16'h0000);
    rchk(ST, 16'h0000);
    rchk(BP, 16'h0088);
    rchk(EC, 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wreg(rows[i].idx, rows[i].data);
      end else begin
        rchk(rows[i].idx, rows[i].data);
      end
    end
    for (int b = 3; b < 16; b++) begin
      wreg(BP, 16'h0001 << b);
      rchk(BP, (16'h0001 << b) & phy_mgmt_pkg::BYPASS_RW);
      check("bypass out", 16'(bypass), ((16'h0001 << b) & phy_mgmt_pkg::BYPASS_RW) >> 3);
    end
    wreg(8'h00, 16'h0000);
    rchk(8'h00, 16'h0000);
    pulse_np(16'hA9A5);
    rchk(LP, 16'hA9A5);
    pulse_np(16'h5123);
    rchk(LP, 16'h5123);
    // a word arriving during the read's address phase is what the read returns
    fork
      pulse_np(16'h0800);
      rchk(LP, 16'h0800);
    join
    link <= 2'b11;
    pulse_ev(7'h6F);
    rchk(ST, 16'hFF00);
    rchk(ST, 16'h9000);
    link <= 2'b00;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      if (i != 4) begin
        pulse_ev(7'h01 << i);
        rchk(ST, 16'h0100 << i);
        rchk(ST, 16'h0000);
      end
    end
    // an event in the clearing cycle survives the clear
    fork
      begin
        @(posedge clk);
        pulse_ev(7'h08);
      end
      rchk(ST, 16'h0000);
    join
    rchk(ST, 16'h0800);
    pulse_rx(3);
    rchk(EC, 16'h0003);
    rchk(EC, 16'h0000);
    pulse_rx(260);
    rchk(EC, 16'h00FF);
    rchk(EC, 16'h0000);
    // an error frame in the clearing cycle is counted
    fork
      begin
        @(posedge clk);
        pulse_rx(1);
      end
      rchk(EC, 16'h0000);
    join
    rchk(EC, 16'h0001);
    wreg(BP, 16'hFEF8);
    wreg(CT, 16'h4003);
    wreg(SC, 16'h8200);
    rchk(BP, 16'h00B8);
    rchk(CT, 16'h0000);
    wreg(BP, 16'h0030);
    wreg(SC, 16'h0000);
    wreg(SC, 16'h8000);
    rchk(BP, 16'h0088);
    check("soft pulses", 16'(n_soft), 16'h0002);
    check("response", 16'(hresp), 16'(phy_mgmt_pkg::HRESP_OK));
    wreg(BP, 16'h8000);
    do_reset();
    rchk(BP, 16'h0088);
    end_sim();
  end
endmodule : testbench
